// ---- logic/line_test_pattern_unit.sv ----
// Per-channel alarm insertion, test pattern generator and pattern detector.
// Assumes path data, loss flags and loopback state come from logic on clk;
// pattern clocks and transmit rails are asynchronous pins.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module line_test_pattern_unit (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Asynchronous pattern clocks and rails
  input wire logic crystal_ref_clock,
  input wire logic rx_recovered_clock,
  input wire logic tx_clock_input,
  input wire logic tx_pos_rail_in,
  input wire logic tx_neg_rail_in,
  // Channel state
  input wire logic tx_rz_format,
  input wire logic remote_loopback,
  input wire logic system_side_signal_loss,
  input wire logic line_side_signal_loss,
  // Data paths
  input wire line_test_pkg::path_bit_s tx_in,
  input wire line_test_pkg::path_bit_s rx_in,
  output line_test_pkg::path_bit_s tx_out,
  output line_test_pkg::path_bit_s rx_out,
  // Detector status
  output logic detect_locked,
  output logic detect_error,
  output logic loop_up_seen,
  output logic loop_down_seen
);

  logic rst_meta;
  logic rst_n;
  logic [7:0] alarm_insert_ctrl;
  logic [7:0] pattern_gen_ctrl;
  logic [7:0] pattern_detect_ctrl;
  logic [23:0] user_word_pattern;
  logic [7:0] loop_code_length_ctrl;
  logic [7:0] gen_loop_code_bits;
  logic [7:0] loop_up_code_bits;
  logic [7:0] loop_down_code_bits;
  logic err_pending;
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic [4:0] pin_prev;
  logic rz_prev;
  logic gen_tick;
  logic [19:0] lfsr;
  logic prbs_fb;
  logic [4:0] user_idx;
  logic [2:0] code_idx;
  logic [2:0] gen_top;
  logic gen_bit;
  logic next_gen_bit;
  logic flip_now;
  logic tx_alarm;
  logic rx_alarm;
  line_test_pkg::gen_mode_e gen_mode;
  line_test_pkg::det_sel_e det_sel;
  line_test_pkg::path_bit_s mon;
  logic mon_bit;
  logic [23:0] det_hist;
  logic [23:0] window;
  logic expected;
  logic [4:0] det_idx;
  logic [5:0] match_cnt;
  logic [2:0] miss_cnt;
  logic [7:0] code_hist;
  logic [7:0] next_code_hist;

  // Reset release
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Mask of the low code bits in use
  function automatic logic [7:0] len_mask(input logic [1:0] len);
    len_mask = {len == 2'h3, len >= 2'h2, len != 2'h0, 5'h1f};
  endfunction

  assign gen_mode = line_test_pkg::gen_mode_e'(pattern_gen_ctrl[line_test_pkg::GEN_EN_LSB +: 2]);
  assign det_sel = line_test_pkg::det_sel_e'(pattern_detect_ctrl[line_test_pkg::DET_SEL_LSB +: 2]);

  // Register writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_insert_ctrl <= line_test_pkg::RST_ALARM;
      pattern_gen_ctrl <= line_test_pkg::RST_GEN;
      pattern_detect_ctrl <= line_test_pkg::RST_DETECT;
      user_word_pattern <= {3{line_test_pkg::RST_USER_BYTE}};
      loop_code_length_ctrl <= line_test_pkg::RST_CODE_LEN;
      gen_loop_code_bits <= line_test_pkg::RST_GEN_CODE;
      loop_up_code_bits <= line_test_pkg::RST_UP_CODE;
      loop_down_code_bits <= line_test_pkg::RST_DOWN_CODE;
    end else if (reg_write) begin
      unique case (reg_addr)
        line_test_pkg::OFS_ALARM: alarm_insert_ctrl <= {3'h0, reg_wdata[4:0]};
        line_test_pkg::OFS_GEN: pattern_gen_ctrl <= {1'b0, reg_wdata[6:0]};
        line_test_pkg::OFS_DETECT: pattern_detect_ctrl <= {4'h0, reg_wdata[3:0]};
        line_test_pkg::OFS_USER_LOW: user_word_pattern[7:0] <= reg_wdata;
        line_test_pkg::OFS_USER_MID: user_word_pattern[15:8] <= reg_wdata;
        line_test_pkg::OFS_USER_HIGH: user_word_pattern[23:16] <= reg_wdata;
        line_test_pkg::OFS_CODE_LEN: loop_code_length_ctrl <= {2'h0, reg_wdata[5:0]};
        line_test_pkg::OFS_GEN_CODE: gen_loop_code_bits <= reg_wdata;
        line_test_pkg::OFS_UP_CODE: loop_up_code_bits <= reg_wdata;
        line_test_pkg::OFS_DOWN_CODE: loop_down_code_bits <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Single error request, cleared when spent
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_pending <= 1'b0;
    end else if (reg_write && reg_addr == line_test_pkg::OFS_ERR_CTRL &&
                 reg_wdata[line_test_pkg::SINGLE_ERROR_INSERT_BIT] && !err_pending) begin
      err_pending <= 1'b1;
    end else if (flip_now) begin
      err_pending <= 1'b0;
    end
  end

  // Register reads, answer in the next cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      unique case (reg_addr)
        line_test_pkg::OFS_ERR_CTRL: reg_rdata <= {2'h0, err_pending, 5'h00};
        line_test_pkg::OFS_ALARM: reg_rdata <= alarm_insert_ctrl;
        line_test_pkg::OFS_GEN: reg_rdata <= pattern_gen_ctrl;
        line_test_pkg::OFS_DETECT: reg_rdata <= pattern_detect_ctrl;
        line_test_pkg::OFS_USER_LOW: reg_rdata <= user_word_pattern[7:0];
        line_test_pkg::OFS_USER_MID: reg_rdata <= user_word_pattern[15:8];
        line_test_pkg::OFS_USER_HIGH: reg_rdata <= user_word_pattern[23:16];
        line_test_pkg::OFS_CODE_LEN: reg_rdata <= loop_code_length_ctrl;
        line_test_pkg::OFS_GEN_CODE: reg_rdata <= gen_loop_code_bits;
        line_test_pkg::OFS_UP_CODE: reg_rdata <= loop_up_code_bits;
        line_test_pkg::OFS_DOWN_CODE: reg_rdata <= loop_down_code_bits;
        line_test_pkg::OFS_STATUS:
          reg_rdata <= {5'h00, loop_down_seen, loop_up_seen, detect_locked};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Pin synchronisers and edge history
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
      pin_prev <= 5'h00;
      rz_prev <= 1'b0;
    end else begin
      pin_meta <= {tx_neg_rail_in, tx_pos_rail_in, tx_clock_input,
                   rx_recovered_clock, crystal_ref_clock};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
      rz_prev <= pin_sync[3] | pin_sync[4];
    end
  end

  // Pattern bit clock select
  always_comb begin
    if (!pattern_gen_ctrl[line_test_pkg::GEN_CLK_BIT]) begin
      gen_tick = pin_sync[0] & ~pin_prev[0];
    end else if (pattern_gen_ctrl[line_test_pkg::GEN_DIR_BIT]) begin
      gen_tick = pin_sync[1] & ~pin_prev[1];
    end else if (tx_rz_format) begin
      gen_tick = (pin_sync[3] | pin_sync[4]) & ~rz_prev;
    end else begin
      gen_tick = pin_sync[2] & ~pin_prev[2];
    end
  end

  // Generator next bit
  always_comb begin
    unique case (pattern_gen_ctrl[line_test_pkg::GEN_PRBS_LSB +: 2])
      2'b00: prbs_fb = lfsr[19] ^ lfsr[16];
      2'b01: prbs_fb = lfsr[14] ^ lfsr[13];
      default: prbs_fb = lfsr[10] ^ lfsr[8];
    endcase
    gen_top = 3'h4 + {1'b0, loop_code_length_ctrl[line_test_pkg::LEN_GEN_LSB +: 2]};
    flip_now = gen_tick && err_pending &&
               (gen_mode == line_test_pkg::GEN_PRBS || gen_mode == line_test_pkg::GEN_USER);
    unique case (gen_mode)
      line_test_pkg::GEN_PRBS:
        next_gen_bit = prbs_fb ^ pattern_gen_ctrl[line_test_pkg::GEN_INV_BIT];
      line_test_pkg::GEN_USER:
        next_gen_bit = user_word_pattern[user_idx] ^
                       pattern_gen_ctrl[line_test_pkg::GEN_INV_BIT];
      line_test_pkg::GEN_CODE:
        next_gen_bit = gen_loop_code_bits[code_idx];
      line_test_pkg::GEN_OFF:
        next_gen_bit = 1'b0;
    endcase
  end

  // Generator state, one step per pattern clock edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr <= line_test_pkg::RST_LFSR;
      user_idx <= line_test_pkg::USER_TOP;
      code_idx <= 3'h4;
      gen_bit <= 1'b0;
    end else if (gen_mode == line_test_pkg::GEN_OFF) begin
      user_idx <= line_test_pkg::USER_TOP;
      code_idx <= gen_top;
      gen_bit <= 1'b0;
    end else if (gen_tick) begin
      gen_bit <= next_gen_bit ^ flip_now;
      if (gen_mode == line_test_pkg::GEN_PRBS) begin
        lfsr <= {lfsr[18:0], prbs_fb};
      end
      if (gen_mode == line_test_pkg::GEN_USER) begin
        user_idx <= (user_idx == 5'h00) ? line_test_pkg::USER_TOP : user_idx - 5'h01;
      end
      if (gen_mode == line_test_pkg::GEN_CODE) begin
        code_idx <= (code_idx == 3'h0 || code_idx > gen_top) ? gen_top : code_idx - 3'h1;
      end
    end
  end

  // Alarm conditions
  assign tx_alarm = (alarm_insert_ctrl[line_test_pkg::TX_FORCE_BIT] & ~remote_loopback) |
                    (alarm_insert_ctrl[line_test_pkg::TX_SYS_BIT] & system_side_signal_loss) |
                    (alarm_insert_ctrl[line_test_pkg::TX_LINE_BIT] & line_side_signal_loss);
  assign rx_alarm = (alarm_insert_ctrl[line_test_pkg::RX_SYS_BIT] & system_side_signal_loss) |
                    (alarm_insert_ctrl[line_test_pkg::RX_LINE_BIT] & line_side_signal_loss);

  // Path outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_out <= '0;
      rx_out <= '0;
    end else begin
      tx_out.strobe <= tx_in.strobe;
      rx_out.strobe <= rx_in.strobe;
      if (tx_alarm) begin
        tx_out.data <= 1'b1;
      end else if (gen_mode != line_test_pkg::GEN_OFF &&
                   !pattern_gen_ctrl[line_test_pkg::GEN_DIR_BIT]) begin
        tx_out.data <= gen_bit;
      end else begin
        tx_out.data <= tx_in.data;
      end
      if (rx_alarm) begin
        rx_out.data <= 1'b1;
      end else if (gen_mode != line_test_pkg::GEN_OFF &&
                   pattern_gen_ctrl[line_test_pkg::GEN_DIR_BIT]) begin
        rx_out.data <= gen_bit;
      end else begin
        rx_out.data <= rx_in.data;
      end
    end
  end

  // Detector input and expected bit
  assign mon = pattern_detect_ctrl[line_test_pkg::DET_DIR_BIT] ? tx_in : rx_in;
  assign mon_bit = mon.data ^ pattern_detect_ctrl[line_test_pkg::DET_INV_BIT];
  assign window = {det_hist[22:0], mon_bit};
  assign next_code_hist = {code_hist[6:0], mon.data};

  always_comb begin
    unique case (det_sel)
      line_test_pkg::DET_PRBS20: expected = det_hist[19] ^ det_hist[16];
      line_test_pkg::DET_PRBS15: expected = det_hist[14] ^ det_hist[13];
      line_test_pkg::DET_PRBS11: expected = det_hist[10] ^ det_hist[8];
      line_test_pkg::DET_USER: expected = user_word_pattern[det_idx];
    endcase
  end

  // Detector synchronisation and compare
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      det_hist <= 24'h00_0000;
      det_idx <= line_test_pkg::USER_TOP;
      match_cnt <= 6'h00;
      miss_cnt <= 3'h0;
      detect_locked <= 1'b0;
      detect_error <= 1'b0;
    end else if (reg_write && reg_addr == line_test_pkg::OFS_DETECT) begin
      match_cnt <= 6'h00;
      miss_cnt <= 3'h0;
      detect_locked <= 1'b0;
      detect_error <= 1'b0;
    end else if (mon.strobe) begin
      det_hist <= window;
      det_idx <= (det_idx == 5'h00) ? line_test_pkg::USER_TOP : det_idx - 5'h01;
      detect_error <= detect_locked && (mon_bit != expected);
      if (!detect_locked) begin
        if (det_sel == line_test_pkg::DET_USER) begin
          if (window == user_word_pattern) begin
            detect_locked <= 1'b1;
            det_idx <= line_test_pkg::USER_TOP;
          end
        end else if (mon_bit == expected) begin
          match_cnt <= match_cnt + 6'h01;
          if (match_cnt + 6'h01 == line_test_pkg::LOCK_MATCHES) begin
            detect_locked <= 1'b1;
          end
        end else begin
          match_cnt <= 6'h00;
        end
        miss_cnt <= 3'h0;
      end else if (mon_bit != expected) begin
        miss_cnt <= miss_cnt + 3'h1;
        if (miss_cnt + 3'h1 == line_test_pkg::UNLOCK_ERRORS) begin
          detect_locked <= 1'b0;
          match_cnt <= 6'h00;
        end
      end else begin
        miss_cnt <= 3'h0;
      end
    end else begin
      detect_error <= 1'b0;
    end
  end

  // Inband code windows, bit 0 last
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code_hist <= 8'h00;
      loop_up_seen <= 1'b0;
      loop_down_seen <= 1'b0;
    end else if (mon.strobe) begin
      code_hist <= next_code_hist;
      loop_up_seen <= ((next_code_hist ^ loop_up_code_bits) &
                       len_mask(loop_code_length_ctrl[line_test_pkg::LEN_UP_LSB +: 2]))
                      == 8'h00;
      loop_down_seen <= ((next_code_hist ^ loop_down_code_bits) &
                         len_mask(loop_code_length_ctrl[line_test_pkg::LEN_DOWN_LSB +: 2]))
                        == 8'h00;
    end
  end

  // Checks
  logic uw_top;
  logic code_lsb;
  assign uw_top = user_word_pattern[23];
  assign code_lsb = gen_loop_code_bits[0];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_tx_force_ones: assert property (
    alarm_insert_ctrl[line_test_pkg::TX_FORCE_BIT] && !remote_loopback |=> tx_out.data)
    else $error("Transmit force did not send ones");
  chk_remote_ignore: assert property (
    alarm_insert_ctrl[line_test_pkg::TX_FORCE_BIT] &&
    remote_loopback && !system_side_signal_loss && !line_side_signal_loss &&
    gen_mode == line_test_pkg::GEN_OFF && !tx_in.data |=> !tx_out.data)
    else $error("Transmit force acted in remote loopback");
  chk_rx_loss_ones: assert property (
    alarm_insert_ctrl[line_test_pkg::RX_LINE_BIT] && line_side_signal_loss |=> rx_out.data)
    else $error("Receive alarm on line loss missing");
  chk_tx_loss_ones: assert property (
    alarm_insert_ctrl[line_test_pkg::TX_SYS_BIT] && system_side_signal_loss |=> tx_out.data)
    else $error("Transmit alarm on system loss missing");
  chk_gen_tx_insert: assert property (
    gen_mode != line_test_pkg::GEN_OFF && !pattern_gen_ctrl[line_test_pkg::GEN_DIR_BIT] &&
    !tx_alarm |=> tx_out.data == $past(gen_bit))
    else $error("Generated bit not on transmit path");
  chk_prbs_invert: assert property (
    gen_mode == line_test_pkg::GEN_PRBS && gen_tick && !err_pending
    |=> gen_bit == ($past(prbs_fb) ^ $past(pattern_gen_ctrl[line_test_pkg::GEN_INV_BIT])))
    else $error("PRBS bit or inversion wrong");
  chk_user_first_bit: assert property (
    gen_mode == line_test_pkg::GEN_USER && gen_tick && !err_pending &&
    !pattern_gen_ctrl[line_test_pkg::GEN_INV_BIT] && user_idx == 5'h17
    |=> gen_bit == $past(uw_top) ##0 user_idx == 5'h16)
    else $error("User word not sent bit 23 first");
  chk_code_period_end: assert property (
    gen_mode == line_test_pkg::GEN_CODE && gen_tick && code_idx == 3'h0 &&
    $stable(pattern_gen_ctrl) |=> gen_bit == $past(code_lsb) ##0 code_idx == $past(gen_top))
    else $error("Code period did not end on bit 0");
  chk_err_self_clear: assert property (
    flip_now |=> !err_pending ##0 gen_bit == !$past(next_gen_bit))
    else $error("Error insertion not done once");

  cov_prbs_lock: cover property ($rose(detect_locked) && det_sel != line_test_pkg::DET_USER);
  cov_error_flip: cover property (flip_now);
  cov_loop_up: cover property ($rose(loop_up_seen));
  cov_rx_gen: cover property (gen_tick && pattern_gen_ctrl[line_test_pkg::GEN_DIR_BIT]);

endmodule // line_test_pattern_unit

`default_nettype wire

// ---- inc/line_test_pkg.sv ----
// Constants, field layout and carrier types for the line test pattern unit.
// Assumes a single 200 MHz clock domain for the register port and data paths.
package line_test_pkg;

  // Register offsets
  localparam logic [7:0] OFS_ERR_CTRL = 8'h0e;
  localparam logic [7:0] OFS_ALARM = 8'h0f;
  localparam logic [7:0] OFS_GEN = 8'h10;
  localparam logic [7:0] OFS_DETECT = 8'h11;
  localparam logic [7:0] OFS_USER_LOW = 8'h12;
  localparam logic [7:0] OFS_USER_MID = 8'h13;
  localparam logic [7:0] OFS_USER_HIGH = 8'h14;
  localparam logic [7:0] OFS_CODE_LEN = 8'h15;
  localparam logic [7:0] OFS_GEN_CODE = 8'h16;
  localparam logic [7:0] OFS_UP_CODE = 8'h17;
  localparam logic [7:0] OFS_DOWN_CODE = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h20;

  // Field positions
  localparam int TX_FORCE_BIT = 4;
  localparam int RX_SYS_BIT = 3;
  localparam int RX_LINE_BIT = 2;
  localparam int TX_SYS_BIT = 1;
  localparam int TX_LINE_BIT = 0;
  localparam int GEN_CLK_BIT = 6;
  localparam int GEN_EN_LSB = 4;
  localparam int GEN_DIR_BIT = 3;
  localparam int GEN_INV_BIT = 2;
  localparam int GEN_PRBS_LSB = 0;
  localparam int DET_DIR_BIT = 3;
  localparam int DET_INV_BIT = 2;
  localparam int DET_SEL_LSB = 0;
  localparam int LEN_GEN_LSB = 4;
  localparam int LEN_UP_LSB = 2;
  localparam int LEN_DOWN_LSB = 0;
  localparam int SINGLE_ERROR_INSERT_BIT = 5;

  // Values after reset
  localparam logic [7:0] RST_ALARM = 8'h00;
  localparam logic [7:0] RST_GEN = 8'h00;
  localparam logic [7:0] RST_DETECT = 8'h03;
  localparam logic [7:0] RST_USER_BYTE = 8'h55;
  localparam logic [7:0] RST_CODE_LEN = 8'h01;
  localparam logic [7:0] RST_GEN_CODE = 8'h00;
  localparam logic [7:0] RST_UP_CODE = 8'h01;
  localparam logic [7:0] RST_DOWN_CODE = 8'h09;
  localparam logic [19:0] RST_LFSR = 20'hf_ffff;

  // Detector counts, in monitored bits
  localparam logic [5:0] LOCK_MATCHES = 6'h20;
  localparam logic [2:0] UNLOCK_ERRORS = 3'h4;
  localparam logic [4:0] USER_TOP = 5'h17;

  typedef enum logic [1:0] {
    GEN_OFF = 2'b00,
    GEN_PRBS = 2'b01,
    GEN_USER = 2'b10,
    GEN_CODE = 2'b11
  } gen_mode_e;

  typedef enum logic [1:0] {
    DET_PRBS20 = 2'b00,
    DET_PRBS15 = 2'b01,
    DET_PRBS11 = 2'b10,
    DET_USER = 2'b11
  } det_sel_e;

  // One bit of a serial data path with its bit strobe
  typedef struct packed {
    logic strobe;
    logic data;
  } path_bit_s;

endpackage

// ---- verif/line_path_model.sv ----
// Far-side model of the channel transmit and receive data paths.
// Assumes the bench calls its tasks from one process, in step with clk.
`timescale 1ns/1ps
`default_nettype none
module line_path_model (
  // Clock
  input wire logic clk,
  // Path bits toward the unit
  output line_test_pkg::path_bit_s tx_in,
  output line_test_pkg::path_bit_s rx_in
);
  logic [14:0] seq = 15'h7fff;
  initial begin
    tx_in = '0;
    rx_in = '0;
  end
  // 2^15-1 sequence on the receive path, continued across calls; bad flips the last bit
  task automatic prbs(input int n, input logic bad);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rx_in <= {1'b1, seq[14] ^ seq[13] ^ (bad && i == n - 1)};
      seq = {seq[13:0], seq[14] ^ seq[13]};
    end
    @(posedge clk);
    rx_in <= 2'b00;
  endtask
  // Steady level on both paths, strobed every cycle
  task automatic hold(input logic d);
    @(posedge clk);
    tx_in <= '{1'b1, d};
    rx_in <= '{1'b1, d};
  endtask
  // Word MSB first on one path; the other path idles with changing data
  task automatic send(input logic to_tx, input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      @(posedge clk);
      tx_in <= to_tx ? {1'b1, w[i]} : {1'b0, ~w[i]};
      rx_in <= to_tx ? {1'b0, ~w[i]} : {1'b1, w[i]};
    end
    @(posedge clk);
    tx_in <= {1'b0, ~w[0]};
    rx_in <= {1'b0, ~w[0]};
  endtask
endmodule // line_path_model
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench for the line test pattern unit.
// Assumes the far-side path model and three free-running pattern clocks.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_count++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module testbench;
  logic clk, resetn, reg_write, reg_read, remote_loopback;
  logic crystal_ref_clock, rx_recovered_clock, tx_clock_input;
  logic rz_clk, rail_sel, rail_pos, rail_neg, tx_rz_format;
  logic system_side_signal_loss, line_side_signal_loss;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic detect_locked, detect_error, loop_up_seen, loop_down_seen;
  line_test_pkg::path_bit_s tx_in, rx_in, tx_out, rx_out;
  int err_count, checks, cyc;
  line_test_pattern_unit DUT (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .crystal_ref_clock(crystal_ref_clock),
    .rx_recovered_clock(rx_recovered_clock), .tx_clock_input(tx_clock_input),
    .tx_pos_rail_in(rail_pos), .tx_neg_rail_in(rail_neg), .tx_rz_format(tx_rz_format),
    .remote_loopback(remote_loopback), .system_side_signal_loss(system_side_signal_loss),
    .line_side_signal_loss(line_side_signal_loss), .tx_in(tx_in), .rx_in(rx_in),
    .tx_out(tx_out), .rx_out(rx_out), .detect_locked(detect_locked),
    .detect_error(detect_error), .loop_up_seen(loop_up_seen), .loop_down_seen(loop_down_seen));
  line_path_model path_far (.clk(clk), .tx_in(tx_in), .rx_in(rx_in));
  // Return-to-zero marks alternate between the two rails
  assign rail_pos = rz_clk & rail_sel;
  assign rail_neg = rz_clk & ~rail_sel;
  initial begin
    rz_clk = 1'b0;
    rail_sel = 1'b0;
    #4;
    forever #35 begin
      rz_clk = ~rz_clk;
      if (!rz_clk) rail_sel = ~rail_sel;
    end
  end
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    crystal_ref_clock = 1'b0;
    #2;
    forever #20 crystal_ref_clock = ~crystal_ref_clock;
  end
  initial begin
    rx_recovered_clock = 1'b0;
    #3;
    forever #25 rx_recovered_clock = ~rx_recovered_clock;
  end
  initial begin
    tx_clock_input = 1'b0;
    #1;
    forever #30 tx_clock_input = ~tx_clock_input;
  end
  task automatic complete_run;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask
  // Alarm control, loss levels and loopback against steady zero data
  task automatic al(input logic [7:0] c, input logic sl, ll, rl, et, er);
    wr(8'h0f, c);
    system_side_signal_loss <= sl;
    line_side_signal_loss <= ll;
    remote_loopback <= rl;
    path_far.hold(1'b0);
    repeat (2) @(posedge clk);
    #1;
    `CHK(tx_out.data, et)
    `CHK(rx_out.data, er)
    `CHK({tx_out.strobe, rx_out.strobe}, 2'b11)
  endtask
  // Sample one bit per pattern clock and look for the repeating pattern
  task automatic gen(input logic [7:0] c, input int s, input logic [23:0] pat, input int per);
    logic [47:0] cap;
    bit hit;
    bit ok;
    int ta, tb;
    hit = 0;
    wr(8'h10, c);
    for (int i = 0; i < 51; i++) begin
      case (s)
        0: @(posedge crystal_ref_clock);
        1: @(posedge rx_recovered_clock);
        3: @(posedge rz_clk);
        default: @(posedge tx_clock_input);
      endcase
      @(posedge clk);
      #1;
      if (i >= 3) cap[i-3] = c[3] ? rx_out.data : tx_out.data;
    end
    // Period 0 asks for the PRBS recurrence of the selected length
    if (per == 0) begin
      ta = c[1] ? 11 : (c[0] ? 15 : 20);
      tb = c[1] ? 9 : (c[0] ? 14 : 17);
      hit = 1;
      for (int i = 20; i < 48; i++) if (cap[i] !== (cap[i-ta] ^ cap[i-tb] ^ c[2])) hit = 0;
    end
    for (int k = 0; k < per; k++) begin
      ok = 1;
      for (int i = 0; i < 40; i++) if (cap[i] !== pat[per-1-((i+k)%per)]) ok = 0;
      hit |= ok;
    end
    `CHK(hit, 1'b1)
  endtask
  task automatic det(input logic [7:0] c, input logic to_tx, input logic [23:0] w, input logic e);
    wr(8'h11, c);
    path_far.send(to_tx, w);
    @(posedge clk);
    #1;
    `CHK(detect_locked, e)
  endtask
  initial begin
    logic [7:0] rv [10] = '{8'h00, 8'h00, 8'h03, 8'h55, 8'h55, 8'h55, 8'h01, 8'h00, 8'h01, 8'h09};
    {reg_write, reg_read, reg_addr, reg_wdata} = '0;
    {remote_loopback, system_side_signal_loss, line_side_signal_loss, tx_rz_format} = '0;
    resetn = 1'b0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 10; i++) rd(8'h0f + 8'(i), rv[i]);
    rd(8'h30, 8'h00);
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h7f);
    wr(8'h10, 8'h00);
    al(8'h10, 0, 0, 0, 1, 0);
    al(8'h10, 0, 0, 1, 0, 0);
    al(8'h0c, 1, 0, 0, 0, 1);
    al(8'h0c, 0, 1, 0, 0, 1);
    al(8'h03, 1, 0, 0, 1, 0);
    al(8'h03, 0, 1, 0, 1, 0);
    al(8'h0c, 0, 0, 0, 0, 0);
    al(8'h00, 1, 1, 0, 0, 0);
    wr(8'h14, 8'ha5);
    wr(8'h13, 8'hc3);
    wr(8'h12, 8'hf0);
    gen(8'h20, 0, 24'ha5_c3f0, 24);
    gen(8'h24, 0, 24'h5a_3c0f, 24);
    gen(8'h28, 0, 24'ha5_c3f0, 24);
    gen(8'h68, 1, 24'ha5_c3f0, 24);
    gen(8'h60, 2, 24'ha5_c3f0, 24);
    tx_rz_format <= 1'b1;
    gen(8'h60, 3, 24'ha5_c3f0, 24);
    tx_rz_format <= 1'b0;
    wr(8'h16, 8'hb6);
    for (int l = 0; l < 4; l++) begin
      wr(8'h15, 8'(l << 4) | 8'h01);
      gen(8'h34, 0, 24'h00_00b6, l + 5);
    end
    gen(8'h10, 0, 24'h00_0000, 0);
    gen(8'h19, 0, 24'h00_0000, 0);
    gen(8'h16, 0, 24'h00_0000, 0);
    wr(8'h10, 8'h00);
    wr(8'h0e, 8'h20);
    rd(8'h0e, 8'h20);
    wr(8'h10, 8'h11);
    repeat (20) @(posedge clk);
    rd(8'h0e, 8'h00);
    wr(8'h10, 8'h20);
    wr(8'h0f, 8'h01);
    line_side_signal_loss <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      #1;
      `CHK(tx_out.data, 1'b1)
    end
    line_side_signal_loss <= 1'b0;
    wr(8'h0f, 8'h00);
    wr(8'h10, 8'h00);
    det(8'h03, 0, 24'ha5_c3f0, 1);
    det(8'h0b, 1, 24'ha5_c3f0, 1);
    det(8'h0b, 0, 24'ha5_c3f0, 0);
    det(8'h07, 0, 24'h5a_3c0f, 1);
    det(8'h07, 0, 24'ha5_c3f0, 0);
    path_far.send(0, 24'h00_0001);
    #1;
    `CHK({loop_up_seen, loop_down_seen}, 2'b10)
    path_far.send(0, 24'h00_0009);
    #1;
    `CHK({loop_up_seen, loop_down_seen}, 2'b01)
    rd(8'h20, 8'h04);
    wr(8'h11, 8'h01);
    path_far.prbs(60, 1'b0);
    #1;
    `CHK({detect_locked, detect_error}, 2'b10)
    path_far.prbs(8, 1'b1);
    #1;
    `CHK({detect_locked, detect_error}, 2'b11)
    complete_run();
  end
endmodule // testbench
`undef CHK
`default_nettype wire
